// File: src/cscp_port.sv
/*
 * Camera sensor capture port: samples sensor pins on core_clk, finds pixel
 * clock edges, qualifies words by mode and pushes them through a buffer.
 * Assumes the pixel clock is well below a quarter of core_clk.
 */
module cscp_port (
	input  wire logic                        core_clk,
	input  wire logic                        rst_b,
	input  wire cscp_pkg::cscp_cfg_s         capture_sensor_config,
	input  wire logic                        sensor_pixel_clock,
	input  wire logic                        sensor_frame_sync,
	input  wire logic                        sensor_line_sync,
	input  wire logic [cscp_pkg::DATA_W-1:0] sensor_data,
	output cscp_pkg::cscp_word_s             pix_word,
	output logic                             pix_valid,
	input  wire logic                        pix_ready,
	output logic                             frame_active,
	output logic                             line_active,
	output logic                             overrun
);

	localparam int W = cscp_pkg::DATA_W;

	typedef enum logic [1:0] { SEQ_IDLE, SEQ_FF, SEQ_Z1, SEQ_Z2 } cscp_seq_e;

	typedef struct packed {
		logic [1:0]   pclk_sy;
		logic [1:0]   fs_sy;
		logic [1:0]   ls_sy;
		logic [1:0][W-1:0] d_sy;
		logic         pclk_d;
		logic         fs_d;
		cscp_seq_e    seq;
		logic         synced;
		logic         frame;
		logic         line;
		logic         fs_pend;
		logic         ls_pend;
		logic         push;
		cscp_pkg::cscp_word_s word;
		logic         ovr;
		logic [1:0]   warm;
	} cscp_port_s;

	cscp_port_s st_r;
	cscp_port_s st_nxt;
	logic       buf_ready;

	// ------------------------------------------------------------------
	// Capture and decode.
	// ------------------------------------------------------------------
	always_comb
	begin
		logic       pclk_n;
		logic       fs_n;
		logic       ls_on;
		logic       edge_hit;
		logic       fs_edge;
		logic [W-1:0] d;
		logic       keep;
		logic       live;
		live     = 1'b0;
		pclk_n   = 1'b0;
		fs_n     = 1'b0;
		ls_on    = 1'b0;
		edge_hit = 1'b0;
		fs_edge  = 1'b0;
		d        = '0;
		keep     = 1'b0;
		st_nxt   = st_r;
		// Two-flop synchronisers; only the second stage is read downstream.
		st_nxt.pclk_sy = {st_r.pclk_sy[0], sensor_pixel_clock};
		st_nxt.fs_sy   = {st_r.fs_sy[0], sensor_frame_sync};
		st_nxt.ls_sy   = {st_r.ls_sy[0], sensor_line_sync};
		st_nxt.d_sy    = {st_r.d_sy[0], sensor_data};
		// Edges and levels count only once the synchronisers and edge flops hold
		// real pin samples, so an inverted setting makes no false edge after reset.
		if (st_r.warm != 2'h3)
			st_nxt.warm = st_r.warm + 2'h1;
		live = (st_r.warm == 2'h3);
		// Polarity normalisation to straight sense.
		pclk_n = st_r.pclk_sy[1] ^ capture_sensor_config.pixel_clock_invert;
		fs_n   = st_r.fs_sy[1] ^ capture_sensor_config.frame_sync_falling;
		ls_on  = live && (st_r.ls_sy[1] ^ capture_sensor_config.line_sync_low);
		st_nxt.pclk_d = pclk_n;
		st_nxt.fs_d   = fs_n;
		edge_hit = live && pclk_n && !st_r.pclk_d;
		fs_edge  = live && fs_n && !st_r.fs_d;
		d        = st_r.d_sy[1];
		st_nxt.push = 1'b0;
		// A word pushed while the buffer is full is lost; flag it one cycle later.
		st_nxt.ovr  = st_r.push && !buf_ready;
		unique case (capture_sensor_config.mode)
			cscp_pkg::CSCP_MODE_EMBEDDED:
			begin
				// Sync pins unused here; codes drive frame and line.
				if (edge_hit)
				begin
					unique case (st_r.seq)
						SEQ_IDLE: st_nxt.seq = (d == cscp_pkg::CODE_PRE_FF) ? SEQ_FF : SEQ_IDLE;
						SEQ_FF:   st_nxt.seq = (d == cscp_pkg::CODE_PRE_00) ? SEQ_Z1 : SEQ_IDLE;
						SEQ_Z1:   st_nxt.seq = (d == cscp_pkg::CODE_PRE_00) ? SEQ_Z2 : SEQ_IDLE;
						SEQ_Z2:
						begin
							// Status word: H=0 with V=0 start code, any other end code.
							st_nxt.seq = SEQ_IDLE;
							if (!d[cscp_pkg::CODE_H_BIT] && !d[cscp_pkg::CODE_V_BIT])
							begin
								if (!st_r.frame)
									st_nxt.fs_pend = 1'b1;
								st_nxt.frame  = 1'b1;
								st_nxt.synced = 1'b1;
								st_nxt.line   = 1'b1;
								st_nxt.ls_pend = 1'b1;
							end
							else
							begin
								st_nxt.line = 1'b0;
								if (d[cscp_pkg::CODE_V_BIT])
									st_nxt.frame = 1'b0;
							end
						end
					endcase
					// Preamble bytes never reach the stream, nor does blanking.
					keep = st_r.line && (st_r.seq == SEQ_IDLE) && (d != cscp_pkg::CODE_PRE_FF);
				end
			end
			cscp_pkg::CSCP_MODE_GATED:
			begin
				if (fs_edge)
				begin
					st_nxt.frame   = 1'b1;
					st_nxt.synced  = 1'b1;
					st_nxt.fs_pend = 1'b1;
				end
				if (ls_on && !st_r.line)
					st_nxt.ls_pend = 1'b1;
				st_nxt.line = ls_on;
				keep = edge_hit && ls_on;
			end
			default:
			begin
				if (fs_edge)
				begin
					st_nxt.frame   = 1'b1;
					st_nxt.synced  = 1'b1;
					st_nxt.fs_pend = 1'b1;
				end
				st_nxt.line = 1'b0;
				keep = edge_hit;
			end
		endcase
		// Hand the word to the buffer; drop before first frame start.
		if (keep && st_nxt.synced)
		begin
			st_nxt.word.data        = d;
			st_nxt.word.frame_start = st_nxt.fs_pend;
			st_nxt.word.line_start  = st_nxt.ls_pend;
			st_nxt.fs_pend          = 1'b0;
			st_nxt.ls_pend          = 1'b0;
			st_nxt.push             = 1'b1;
		end
	end

	// Register the whole state; synchronous active-low reset.
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// ------------------------------------------------------------------
	// Output buffer and status.
	// ------------------------------------------------------------------
	cscp_skid #(
		.W ($bits(cscp_pkg::cscp_word_s))
	) u_buf (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.in_data   (st_r.word),
		.in_valid  (st_r.push),
		.in_ready  (buf_ready),
		.out_data  (pix_word),
		.out_valid (pix_valid),
		.out_ready (pix_ready)
	);

	// Status levels come straight from state flops.
	assign frame_active = st_r.frame;
	assign line_active  = st_r.line;
	assign overrun      = st_r.ovr;

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	property p_no_push_unsynced;
		@(posedge core_clk) disable iff (!rst_b)
		!st_r.synced |=> !st_r.push;
	endproperty
	a_no_push_unsynced: assert property (p_no_push_unsynced)
		else $error("word before frame start");

	property p_gated_line;
		@(posedge core_clk) disable iff (!rst_b)
		(capture_sensor_config.mode == cscp_pkg::CSCP_MODE_GATED && !st_r.line)
			|=> !st_r.push;
	endproperty
	a_gated_line: assert property (p_gated_line)
		else $error("gated capture outside line");

	// Every sync edge seen after the warm-up starts a frame outside embedded mode.
	property p_fs_start;
		@(posedge core_clk) disable iff (!rst_b)
		(capture_sensor_config.mode != cscp_pkg::CSCP_MODE_EMBEDDED && $rose(st_r.fs_d)
			&& $past(st_r.warm) == 2'h3) |-> st_r.frame;
	endproperty
	a_fs_start: assert property (p_fs_start)
		else $error("frame not started on sync edge");

	// The push flop rises in the same cycle as the edge flop that saw the edge.
	property p_push_edge;
		@(posedge core_clk) disable iff (!rst_b)
		st_r.push |-> st_r.pclk_d && !$past(st_r.pclk_d);
	endproperty
	a_push_edge: assert property (p_push_edge)
		else $error("capture without clock edge");

	property p_emb_blank;
		@(posedge core_clk) disable iff (!rst_b)
		(capture_sensor_config.mode == cscp_pkg::CSCP_MODE_EMBEDDED && !st_r.line)
			|=> !st_r.push;
	endproperty
	a_emb_blank: assert property (p_emb_blank)
		else $error("blanking word captured");

	property p_one_per_edge;
		@(posedge core_clk) disable iff (!rst_b)
		st_r.push |=> !st_r.push;
	endproperty
	a_one_per_edge: assert property (p_one_per_edge)
		else $error("two words for one edge");

	property p_ng_noline;
		@(posedge core_clk) disable iff (!rst_b)
		capture_sensor_config.mode == cscp_pkg::CSCP_MODE_NONGATED |=> !st_r.line;
	endproperty
	a_ng_noline: assert property (p_ng_noline)
		else $error("line sync used in non-gated");

	// Starts only out of reset, so the edge flop's reset value is never compared.
	property p_pol_sample;
		@(posedge core_clk) disable iff (!rst_b)
		rst_b |=> st_r.pclk_d == ($past(st_r.pclk_sy[1])
			^ $past(capture_sensor_config.pixel_clock_invert));
	endproperty
	a_pol_sample: assert property (p_pol_sample)
		else $error("clock polarity not applied");

	c_frame: cover property (@(posedge core_clk) st_r.push && st_r.word.frame_start);
	c_line: cover property (@(posedge core_clk) st_r.push && st_r.word.line_start);
	c_stall: cover property (@(posedge core_clk) pix_valid && !pix_ready && !buf_ready);

endmodule : cscp_port

// File: src/cscp_pkg.sv
/*
 * Shared types and constants for the camera sensor capture port.
 * Assumes a single core clock domain at 250 MHz; sensor pins are asynchronous.
 */
package cscp_pkg;

	// ------------------------------------------------------------------
	// Timing modes and widths
	// ------------------------------------------------------------------
	typedef enum logic [1:0]
	{
		CSCP_MODE_EMBEDDED = 2'h0,
		CSCP_MODE_GATED    = 2'h1,
		CSCP_MODE_NONGATED = 2'h2
	} cscp_mode_e;

	localparam int DATA_W = 8;

	// Timing-code preamble bytes and field positions inside the status byte.
	localparam logic [7:0] CODE_PRE_FF = 8'hff;
	localparam logic [7:0] CODE_PRE_00 = 8'h00;
	localparam int         CODE_F_BIT  = 6;
	localparam int         CODE_V_BIT  = 5;
	localparam int         CODE_H_BIT  = 4;

	// Static configuration, steered by software through plain ports.
	typedef struct packed {
		cscp_mode_e mode;
		logic       frame_sync_falling;
		logic       line_sync_low;
		logic       pixel_clock_invert;
	} cscp_cfg_s;

	// One captured word with its frame and line markers.
	typedef struct packed {
		logic              frame_start;
		logic              line_start;
		logic [DATA_W-1:0] data;
	} cscp_word_s;

endpackage : cscp_pkg

// File: src/cscp_skid.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes producer and consumer share core_clk.
 */
module cscp_skid #(
	parameter int W = 10
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);

	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic              rd;
		logic              wr;
		logic [1:0]        cnt;
	} cscp_skid_s;

	cscp_skid_s st_r;
	cscp_skid_s st_nxt;

	assign in_ready  = (st_r.cnt != 2'h2);
	assign out_valid = (st_r.cnt != 2'h0);
	assign out_data  = st_r.mem[st_r.rd];

	// ------------------------------------------------------------------
	// Pointer and occupancy update.
	// ------------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		if (in_valid && in_ready)
		begin
			st_nxt.mem[st_r.wr] = in_data;
			st_nxt.wr           = ~st_r.wr;
		end
		if (out_valid && out_ready)
			st_nxt.rd = ~st_r.rd;
		st_nxt.cnt = st_r.cnt + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
	end

	// Register the state; reset empties the buffer.
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// A full buffer that is not drained stays full; nothing is overwritten.
	property p_no_overflow;
		@(posedge core_clk) disable iff (!rst_b)
		(st_r.cnt == 2'h2 && !out_ready) |=> (st_r.cnt == 2'h2);
	endproperty
	a_no_overflow: assert property (p_no_overflow)
		else $error("buffer lost a word");

endmodule : cscp_skid

// File: tb/cscp_sensor_model.sv
/*
 * Behavioural image sensor that drives the capture port's pins.
 * Assumes the bench calls its tasks one at a time; pin timing is its own.
 */
module cscp_sensor_model (
	output logic       sensor_pixel_clock,
	output logic       sensor_frame_sync,
	output logic       sensor_line_sync,
	output logic [7:0] sensor_data,
	input  wire logic  inv
);
	timeunit 1ns;
	timeprecision 100ps;

	// --------------------------------------------------------------
	// Pin tasks
	// --------------------------------------------------------------
	// Pins idle with the pixel clock held low.
	initial
	begin
		sensor_pixel_clock = 1'b0;
		sensor_frame_sync  = 1'b0;
		sensor_line_sync   = 1'b0;
		sensor_data        = 8'h00;
	end

	// One word, good only around the selected clock edge.
	task automatic put(input logic [7:0] b);
		sensor_data = inv ? ~b : b;
		#31;
		sensor_pixel_clock = 1'b1;
		#31;
		sensor_data = inv ? b : ~b;
		#31;
		sensor_pixel_clock = 1'b0;
		#32;
		sensor_data = ~b; // Released bus shows no stale word.
	endtask : put

	// Sync levels held for one pixel period; lines are held whole.
	task automatic sync(input logic f, input logic l);
		sensor_frame_sync = f;
		sensor_line_sync  = l;
		#125;
	endtask : sync
endmodule : cscp_sensor_model

// File: tb/cscp_port_tb.sv
/*
 * Self-checking bench for the capture port.
 * Assumes the port sources and the sensor model are compiled first.
 */
module cscp_port_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// --------------------------------------------------------------
	// Signals
	// --------------------------------------------------------------
	logic                 core_clk = 1'b0;
	logic                 rst_b;
	logic                 pix_ready;
	cscp_pkg::cscp_cfg_s  capture_sensor_config;
	logic                 sensor_pixel_clock;
	logic                 sensor_frame_sync;
	logic                 sensor_line_sync;
	logic [7:0]           sensor_data;
	cscp_pkg::cscp_word_s pix_word;
	logic                 pix_valid;
	logic                 frame_active;
	logic                 line_active;
	logic                 overrun;
	logic [9:0]           got[$];
	int                   num_errors = 0;
	int                   cmp_count = 0;
	int                   ovr = 0;

	// Free-running core clock.
	always #2 core_clk = ~core_clk;

	cscp_port dut (
		.core_clk              (core_clk),
		.rst_b                 (rst_b),
		.capture_sensor_config (capture_sensor_config),
		.sensor_pixel_clock    (sensor_pixel_clock),
		.sensor_frame_sync     (sensor_frame_sync),
		.sensor_line_sync      (sensor_line_sync),
		.sensor_data           (sensor_data),
		.pix_word              (pix_word),
		.pix_valid             (pix_valid),
		.pix_ready             (pix_ready),
		.frame_active          (frame_active),
		.line_active           (line_active),
		.overrun               (overrun)
	);
	cscp_sensor_model sens (
		.sensor_pixel_clock (sensor_pixel_clock),
		.sensor_frame_sync  (sensor_frame_sync),
		.sensor_line_sync   (sensor_line_sync),
		.sensor_data        (sensor_data),
		.inv                (capture_sensor_config.pixel_clock_invert)
	);

	// Collects accepted words and counts lost-word pulses.
	always @(posedge core_clk)
	begin
		if (pix_valid === 1'b1 && pix_ready)
			got.push_back(pix_word);
		if (overrun === 1'b1)
			ovr++;
	end

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// Compares the collected words under a mask, then empties the list.
	task automatic expect_words(input logic [9:0] e[$], input logic [9:0] m);
		repeat (40) @(posedge core_clk);
		chk(10'(got.size()), 10'(e.size()));
		foreach (e[i])
			chk(got[i] & m, e[i]);
		got.delete();
	endtask : expect_words

	// Resets the port under a new mode and polarity setting.
	task automatic setup(input logic [1:0] m, input logic [2:0] pol);
		@(posedge core_clk);
		rst_b <= 1'b0;
		capture_sensor_config <= cscp_pkg::cscp_cfg_s'({m, pol});
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
	endtask : setup

	task automatic tally_and_finish;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_gated;
		setup(2'h1, 3'h0);
		sens.sync(1'b0, 1'b1);
		sens.put(8'h5a); // Dropped before any frame start.
		sens.sync(1'b0, 1'b0);
		sens.sync(1'b1, 1'b0);
		chk(10'(frame_active), 10'h001);
		sens.sync(1'b1, 1'b1);
		chk(10'(line_active), 10'h001);
		sens.put(8'h11);
		sens.put(8'h22);
		sens.sync(1'b1, 1'b0);
		chk(10'(line_active), 10'h000);
		sens.put(8'h33); // Clock outside a line is ignored.
		sens.sync(1'b1, 1'b1);
		sens.put(8'h44);
		expect_words('{10'h311, 10'h022, 10'h144}, 10'h3ff);
		$display("gated test done");
	endtask : t_gated

	task automatic t_polarity;
		setup(2'h1, 3'h7);
		sens.sync(1'b1, 1'b1);
		sens.sync(1'b0, 1'b1);
		sens.sync(1'b0, 1'b0);
		sens.put(8'hc3);
		sens.sync(1'b0, 1'b1);
		sens.put(8'h3c);
		expect_words('{10'h3c3}, 10'h3ff);
		$display("polarity test done");
	endtask : t_polarity

	task automatic t_embedded;
		logic [7:0] s[$] = '{8'h77, 8'hff, 8'h00, 8'h00, 8'h80, 8'h61, 8'h62, 8'hff,
			8'h00, 8'h00, 8'h90, 8'h10, 8'h10, 8'hff, 8'h00, 8'h00, 8'h80, 8'h63};
		setup(2'h0, 3'h0);
		sens.sync(1'b0, 1'b0);
		sens.sync(1'b1, 1'b0); // Sync pins carry no meaning here.
		foreach (s[i])
			sens.put(s[i]);
		chk(10'(frame_active), 10'h001);
		expect_words('{10'h361, 10'h062, 10'h163}, 10'h3ff);
		$display("embedded test done");
	endtask : t_embedded

	task automatic t_nongated;
		setup(2'h2, 3'h0);
		pix_ready <= 1'b0;
		ovr = 0;
		sens.sync(1'b0, 1'b0);
		sens.sync(1'b1, 1'b0);
		sens.put(8'hb1);
		sens.put(8'hb2);
		sens.put(8'hb3);
		repeat (20) @(posedge core_clk);
		chk(10'(ovr), 10'h001);
		chk(10'(got.size()), 10'h000);
		chk(10'(line_active), 10'h000);
		pix_ready <= 1'b1;
		expect_words('{10'h2b1, 10'h0b2}, 10'h3ff);
		$display("non-gated test done");
	endtask : t_nongated

	// Main sequence.
	initial
	begin
		rst_b                 <= 1'b0;
		pix_ready             <= 1'b1;
		capture_sensor_config <= '0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		t_gated();
		t_polarity();
		t_embedded();
		t_nongated();
		tally_and_finish();
	end

	// Cuts a hung run short.
	initial
	begin
		#200000;
		num_errors++;
		tally_and_finish();
	end
endmodule : cscp_port_tb
